// ### design/irq_prio_pkg.sv
package irq_prio_pkg;
   // vector space and widths
   localparam int NUM_VEC = 16;
   localparam int VEC_W   = 4;
   localparam int ADDR_W  = 8;
   localparam int PC_W    = 16;
   localparam int DATA_W  = 32;

   // lines that are non-maskable; fixed per device, never configurable
   localparam logic [NUM_VEC-1:0] NMI_LINES = 16'h0001;

   // vector placement: vector n sits at VEC_BASE + n * VEC_STRIDE
   localparam logic [PC_W-1:0] VEC_BASE   = 16'h0002;
   localparam logic [PC_W-1:0] VEC_STRIDE = 16'h0002;
   // compact table addresses
   localparam logic [PC_W-1:0] CVT_NMI_ADDR = 16'h0001;
   localparam logic [PC_W-1:0] CVT_L1_ADDR  = 16'h0002;
   localparam logic [PC_W-1:0] CVT_L0_ADDR  = 16'h0003;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CTRL  = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_PRIO  = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_L1VEC = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATE = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_EVT   = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_MASK  = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_PEND  = 8'h18;

   // field positions
   localparam int CTRL_RR_BIT  = 0;
   localparam int CTRL_CVT_BIT = 1;
   localparam int L1_EN_BIT    = 7;

   // reset values
   localparam logic [VEC_W-1:0] PRIO_RST  = 4'h0;
   localparam logic [VEC_W-1:0] L1VEC_RST = 4'h0;

   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // level codes; the state register and the event bits share this layout
   typedef enum logic [2:0] {
      LVL_NORMAL = 3'b001,
      LVL_HIGH   = 3'b010,
      LVL_NMI    = 3'b100
   } level_e;
   localparam logic [2:0] LVL_NONE = 3'h0;
endpackage

// ### design/rot_arbiter.sv
`timescale 1ns/1ps
// picks one request; low_ptr zero gives plain lowest-number-first order,
// otherwise low_ptr ranks last and low_ptr+1 ranks first, wrapping
module rot_arbiter (
   input  wire logic [irq_prio_pkg::NUM_VEC-1:0] req,
   input  wire logic [irq_prio_pkg::VEC_W-1:0]   low_ptr,
   output logic                                  found,
   output logic [irq_prio_pkg::VEC_W-1:0]        win
);
   import irq_prio_pkg::*;

   // scan from lowest rank up so the highest-ranked request is kept last
   always_comb begin
      logic [VEC_W-1:0] start;
      logic [VEC_W-1:0] idx;
      start = '0;
      idx   = '0;
      found = 1'b0;
      win   = '0;
      start = (low_ptr == '0) ? '0 : low_ptr + 4'h1;
      for (int k = NUM_VEC - 1; k >= 0; k--) begin
         idx = start + k[VEC_W-1:0];
         if (req[idx]) begin
            found = 1'b1;
            win   = idx;
         end
      end
   end
endmodule

// ### design/cpu_irq_controller.sv
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module cpu_irq_controller (
   input  wire logic                               core_clk,
   input  wire logic                               resetn,
   input  wire logic [irq_prio_pkg::ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                               s_axi_awvalid,
   output logic                                    s_axi_awready,
   input  wire logic [irq_prio_pkg::DATA_W-1:0]    s_axi_wdata,
   input  wire logic [3:0]                         s_axi_wstrb,
   input  wire logic                               s_axi_wvalid,
   output logic                                    s_axi_wready,
   output logic [1:0]                              s_axi_bresp,
   output logic                                    s_axi_bvalid,
   input  wire logic                               s_axi_bready,
   input  wire logic [irq_prio_pkg::ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                               s_axi_arvalid,
   output logic                                    s_axi_arready,
   output logic [irq_prio_pkg::DATA_W-1:0]         s_axi_rdata,
   output logic [1:0]                              s_axi_rresp,
   output logic                                    s_axi_rvalid,
   input  wire logic                               s_axi_rready,
   input  wire logic [irq_prio_pkg::NUM_VEC-1:0]   irq_req,
   input  wire logic                               global_ie,
   input  wire logic                               instr_retire,
   input  wire logic                               return_from_handler_instr,
   input  wire logic                               debug_halt,
   output logic                                    pc_load,
   output logic [irq_prio_pkg::PC_W-1:0]           pc_addr,
   output logic [irq_prio_pkg::VEC_W-1:0]          ack_vec,
   output logic [2:0]                              ack_level,
   output logic [2:0]                              level_state,
   output logic                                    irq_out
);
   import irq_prio_pkg::*;

   logic               wr_rdy_reg, bvalid_reg, rd_rdy_reg, rvalid_reg;
   logic [1:0]         bresp_reg, rresp_reg;
   logic [DATA_W-1:0]  rdata_reg;
   logic               rr_enable_reg, compact_table_enable_reg;
   logic [VEC_W-1:0]   normal_priority_pointer_reg, l1_vec_reg;
   logic               l1_en_reg;
   logic [2:0]         state_reg, evt_reg, mask_reg;
   logic               block_reg, pc_load_reg, irq_out_reg;
   logic [PC_W-1:0]    pc_addr_reg;
   logic [VEC_W-1:0]   ack_vec_reg;
   logic [2:0]         ack_level_reg;

   // bus decode; write address and data are taken together in one beat
   wire wr_go  = wr_rdy_reg & s_axi_awvalid & s_axi_wvalid;
   wire rd_go  = rd_rdy_reg & s_axi_arvalid;
   wire wr_lo  = wr_go & s_axi_wstrb[0];
   wire wr_ok  = (s_axi_awaddr <= OFF_PEND) & (s_axi_awaddr[1:0] == 2'h0);
   wire rd_ok  = (s_axi_araddr <= OFF_PEND) & (s_axi_araddr[1:0] == 2'h0);
   wire wr_ctl = wr_lo & (s_axi_awaddr == OFF_CTRL);
   wire wr_pri = wr_lo & (s_axi_awaddr == OFF_PRIO);
   wire wr_l1  = wr_lo & (s_axi_awaddr == OFF_L1VEC);
   wire wr_evt = wr_lo & (s_axi_awaddr == OFF_EVT);
   wire wr_msk = wr_lo & (s_axi_awaddr == OFF_MASK);

   // request conditioning: sources gate their own enables, and a line
   // counts only while it is held high, so a dropped line simply vanishes
   wire [NUM_VEC-1:0] req_live = irq_req;
   wire [NUM_VEC-1:0] l1_mask  = l1_en_reg ?
                                 (16'h0001 << l1_vec_reg) : '0;
   wire [NUM_VEC-1:0] nmi_req  = req_live & NMI_LINES;
   wire [NUM_VEC-1:0] l0_req   = req_live & ~NMI_LINES & ~l1_mask;
   wire               l1_hit   = |(req_live & l1_mask & ~NMI_LINES);

   logic             nmi_found, l0_found;
   logic [VEC_W-1:0] nmi_win, l0_win;

   // nmi order is static, lowest number first
   rot_arbiter u_nmi_arb (
      .req     (nmi_req),
      .low_ptr (PRIO_RST),
      .found   (nmi_found),
      .win     (nmi_win)
   );

   // normal order follows the pointer, zero meaning plain static order
   rot_arbiter u_l0_arb (
      .req     (l0_req),
      .low_ptr (normal_priority_pointer_reg),
      .found   (l0_found),
      .win     (l0_win)
   );

   // service decision; halt freezes everything but the bus
   wire active   = ~debug_halt;
   wire can_take = active & ~block_reg &
                   ~return_from_handler_instr;
   wire in_nmi   = state_reg[2];
   wire take_nmi = can_take & nmi_found & ~in_nmi;
   wire take_l1  = can_take & ~take_nmi & ~in_nmi & global_ie &
                   l1_hit & ~state_reg[1];
   wire take_l0  = can_take & ~take_nmi & ~take_l1 & ~in_nmi &
                   global_ie & l0_found &
                   ~state_reg[1] & ~state_reg[0];
   wire ack_fire = take_nmi | take_l1 | take_l0;

   wire [VEC_W-1:0] sel_vec = take_nmi ? nmi_win :
                              take_l1  ? l1_vec_reg : l0_win;
   wire [2:0] sel_level = take_nmi ? LVL_NMI :
                          take_l1  ? LVL_HIGH :
                          take_l0  ? LVL_NORMAL : LVL_NONE;

   // vector address; the compact table folds each level onto one slot
   wire [PC_W-1:0] full_addr = VEC_BASE +
                               {12'h000, sel_vec} * VEC_STRIDE;
   wire [PC_W-1:0] cvt_addr  = take_nmi ? CVT_NMI_ADDR :
                               take_l1  ? CVT_L1_ADDR : CVT_L0_ADDR;
   wire [PC_W-1:0] sel_addr  = compact_table_enable_reg ?
                               cvt_addr : full_addr;

   // return drops the innermost level only; nothing goes to the stack
   wire [2:0] return_from_handler_instr_clr = state_reg[2] ? LVL_NMI :
                         state_reg[1] ? LVL_HIGH :
                         state_reg[0] ? LVL_NORMAL : LVL_NONE;
   wire       return_from_handler_instr_act = active & return_from_handler_instr;
   wire [2:0] state_next = ack_fire ? (state_reg | sel_level) :
                           return_from_handler_instr_act ? (state_reg & ~return_from_handler_instr_clr) :
                           state_reg;

   // guard against back-to-back service with no instruction between
   wire block_next = (ack_fire | return_from_handler_instr_act) ? 1'b1 :
                     (active & instr_retire) ? 1'b0 : block_reg;

   // hardware pointer update wins over a software write in the same cycle
   wire [VEC_W-1:0] ptr_next =
      (take_l0 & rr_enable_reg) ? l0_win :
      wr_pri ? s_axi_wdata[VEC_W-1:0] :
      normal_priority_pointer_reg;

   // event bits: a fresh ack beats a write-one-to-clear in the same cycle
   wire [2:0] evt_clr  = wr_evt ? s_axi_wdata[2:0] : LVL_NONE;
   wire [2:0] evt_next = (evt_reg & ~evt_clr) | sel_level;
   wire [2:0] mask_next = wr_msk ? s_axi_wdata[2:0] : mask_reg;

   // read mux, unused bits read zero
   logic [DATA_W-1:0] rd_mux;
   always_comb begin
      case (s_axi_araddr)
         OFF_CTRL:  rd_mux = {30'h0, compact_table_enable_reg,
                              rr_enable_reg};
         OFF_PRIO:  rd_mux = {28'h0, normal_priority_pointer_reg};
         OFF_L1VEC: rd_mux = {24'h0, l1_en_reg, 3'h0, l1_vec_reg};
         OFF_STATE: rd_mux = {29'h0, state_reg};
         OFF_EVT:   rd_mux = {29'h0, evt_reg};
         OFF_MASK:  rd_mux = {29'h0, mask_reg};
         OFF_PEND:  rd_mux = {16'h0, req_live};
         default:   rd_mux = 32'h0000_0000;
      endcase
   end

   // bus handshakes: write ready is a one-cycle pulse once both valids stand, read ready once arvalid stands
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         wr_rdy_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
         rd_rdy_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg  <= RESP_OKAY;
         rdata_reg  <= '0;
      end else begin
         wr_rdy_reg <= ~wr_rdy_reg & ~bvalid_reg &
                       s_axi_awvalid & s_axi_wvalid;
         bvalid_reg <= wr_go | (bvalid_reg & ~s_axi_bready);
         if (wr_go) bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         rd_rdy_reg <= ~rd_rdy_reg & ~rvalid_reg & s_axi_arvalid;
         rvalid_reg <= rd_go | (rvalid_reg & ~s_axi_rready);
         if (rd_go) begin
            rdata_reg <= rd_mux;
            rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // configuration registers
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rr_enable_reg            <= 1'b0;
         compact_table_enable_reg <= 1'b0;
         l1_vec_reg               <= L1VEC_RST;
         l1_en_reg                <= 1'b0;
         mask_reg                 <= LVL_NONE;
      end else begin
         if (wr_ctl) begin
            rr_enable_reg            <= s_axi_wdata[CTRL_RR_BIT];
            compact_table_enable_reg <= s_axi_wdata[CTRL_CVT_BIT];
         end
         if (wr_l1) begin
            l1_vec_reg <= s_axi_wdata[VEC_W-1:0];
            l1_en_reg  <= s_axi_wdata[L1_EN_BIT];
         end
         mask_reg <= mask_next;
      end
   end

   // controller state, all on the core clock
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state_reg                   <= LVL_NONE;
         block_reg                   <= 1'b1;
         normal_priority_pointer_reg <= PRIO_RST;
         evt_reg                     <= LVL_NONE;
         irq_out_reg                 <= 1'b0;
      end else begin
         state_reg                   <= state_next;
         block_reg                   <= block_next;
         normal_priority_pointer_reg <= ptr_next;
         evt_reg                     <= evt_next;
         irq_out_reg                 <= |(evt_next & mask_next);
      end
   end

   // core redirect; pc_load is a one-cycle pulse with its address
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         pc_load_reg   <= 1'b0;
         pc_addr_reg   <= '0;
         ack_vec_reg   <= '0;
         ack_level_reg <= LVL_NONE;
      end else begin
         pc_load_reg <= ack_fire;
         if (ack_fire) begin
            pc_addr_reg   <= sel_addr;
            ack_vec_reg   <= sel_vec;
            ack_level_reg <= sel_level;
         end
      end
   end

   assign s_axi_awready = wr_rdy_reg;
   assign s_axi_wready  = wr_rdy_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = rd_rdy_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = rdata_reg;
   assign pc_load       = pc_load_reg;
   assign pc_addr       = pc_addr_reg;
   assign ack_vec       = ack_vec_reg;
   assign ack_level     = ack_level_reg;
   assign level_state   = state_reg;
   assign irq_out       = irq_out_reg;

   // checks on the outputs against their causes
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   sequence s_two_quiet;
      !pc_load_reg ##1 !pc_load_reg;
   endsequence
   property p_return_from_handler_instr_gap;
      return_from_handler_instr && !debug_halt |=> s_two_quiet;
   endproperty
   a_return_from_handler_instr_gap: assert property (p_return_from_handler_instr_gap)
      else $error("service right after return");
   // without a retire beside the redirect the block flag keeps two
   // further cycles quiet; a retire in that cycle may free the next edge
   property p_ack_gap;
      pc_load_reg && !instr_retire |=> s_two_quiet;
   endproperty
   a_ack_gap: assert property (p_ack_gap)
      else $error("two services back to back");
   property p_cvt_addr;
      pc_load_reg && compact_table_enable_reg &&
         ack_level_reg == LVL_NORMAL |-> pc_addr_reg == CVT_L0_ADDR;
   endproperty
   a_cvt_addr: assert property (p_cvt_addr)
      else $error("compact normal vector not at slot three");
   property p_mask_gie;
      pc_load_reg && ack_level_reg != LVL_NMI |-> $past(global_ie);
   endproperty
   a_mask_gie: assert property (p_mask_gie)
      else $error("maskable taken with global enable low");
   property p_halt_freeze;
      debug_halt |=> !pc_load_reg && $stable(state_reg);
   endproperty
   a_halt_freeze: assert property (p_halt_freeze)
      else $error("activity while core halted");
   property p_rr_ptr;
      pc_load_reg && rr_enable_reg && ack_level_reg == LVL_NORMAL |->
         normal_priority_pointer_reg == ack_vec_reg;
   endproperty
   a_rr_ptr: assert property (p_rr_ptr)
      else $error("pointer not loaded with last normal ack");
   property p_nmi_hold;
      state_reg[2] |=> !(pc_load_reg && ack_level_reg != LVL_NMI);
   endproperty
   a_nmi_hold: assert property (p_nmi_hold)
      else $error("nmi handler preempted");
   property p_l1_preempt;
      pc_load_reg && ack_level_reg == LVL_HIGH |->
         state_reg[1] && $past(!state_reg[1]);
   endproperty
   a_l1_preempt: assert property (p_l1_preempt)
      else $error("high ack did not raise high state");
   property p_l0_pending;
      state_reg[0] && !return_from_handler_instr |=>
         !(pc_load_reg && ack_level_reg == LVL_NORMAL);
   endproperty
   a_l0_pending: assert property (p_l0_pending)
      else $error("normal taken during normal handler");
   property p_return_from_handler_instr_nmi;
      return_from_handler_instr && !debug_halt && state_reg[2] |=>
         !state_reg[2] && state_reg[1:0] == $past(state_reg[1:0]);
   endproperty
   a_return_from_handler_instr_nmi: assert property (p_return_from_handler_instr_nmi)
      else $error("return did not restore prior level");
endmodule

// ### tb/core_model.sv
`timescale 1ns/1ps
// stand-in for the core and the peripheral sources; all outputs are
// registered so the controller never sees a change at its sampling edge
module core_model (
   input  wire logic                             core_clk,
   input  wire logic                             resetn,
   input  wire logic [irq_prio_pkg::NUM_VEC-1:0] src_en,
   input  wire logic [irq_prio_pkg::NUM_VEC-1:0] src_cond,
   input  wire logic                             ie_cmd,
   input  wire logic                             retire_cmd,
   input  wire logic                             ret_cmd,
   output logic [irq_prio_pkg::NUM_VEC-1:0]      irq_req,
   output logic                                  global_ie,
   output logic                                  instr_retire,
   output logic                                  return_from_handler_instr
);
   import irq_prio_pkg::*;

   // requests follow enable and condition level by level
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         irq_req                   <= '0;
         global_ie                 <= 1'b0;
         instr_retire              <= 1'b0;
         return_from_handler_instr <= 1'b0;
      end else begin
         irq_req                   <= src_en & src_cond;
         global_ie                 <= ie_cmd;  // only software moves it
         instr_retire              <= retire_cmd;
         return_from_handler_instr <= ret_cmd;
      end
   end
endmodule

// ### tb/tb_cpu_irq_controller.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("unexpected t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_cpu_irq_controller;
   import irq_prio_pkg::*;
   logic                core_clk = 1'b0;
   logic                resetn = 1'b0;
   logic [ADDR_W-1:0]   s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [DATA_W-1:0]   s_axi_wdata = '0, s_axi_rdata, rd;
   logic [3:0]          s_axi_wstrb = 4'hF;
   logic                s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic                s_axi_arvalid = 0, s_axi_rready = 0, debug_halt = 0;
   logic                s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic                s_axi_arready, s_axi_rvalid, pc_load, irq_out;
   logic                global_ie, instr_retire, return_from_handler_instr;
   logic [1:0]          s_axi_bresp, s_axi_rresp, rsp;
   logic [NUM_VEC-1:0]  irq_req, src_en = '1, src_cond = '0;
   logic                ie_cmd = 1'b1, retire_cmd = 1'b0, ret_cmd = 1'b0;
   logic [PC_W-1:0]     pc_addr;
   logic [VEC_W-1:0]    ack_vec;
   logic [2:0]          ack_level, level_state;
   int                  errors = 0;
   int                  cmp_count = 0;

   always #12.5 core_clk = ~core_clk;

   cpu_irq_controller DUT (.core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .irq_req, .global_ie, .instr_retire,
      .return_from_handler_instr, .debug_halt, .pc_load, .pc_addr, .ack_vec,
      .ack_level, .level_state, .irq_out);

   core_model partner (.core_clk, .resetn, .src_en, .src_cond, .ie_cmd,
      .retire_cmd, .ret_cmd, .irq_req, .global_ie, .instr_retire,
      .return_from_handler_instr);

   task print_verdict();
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // address and data offered together, each released once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge core_clk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a);
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge core_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e,
                         input logic [1:0] r);
      axr(a);
      `CHK(rd, e)
      `CHK(rsp, r)
   endtask

   task setreq(input logic [NUM_VEC-1:0] m);
      @(posedge core_clk);
      src_cond <= m;
   endtask

   task set_ie(input logic v);
      @(posedge core_clk);
      ie_cmd <= v;
   endtask

   task retire();
      @(posedge core_clk);
      retire_cmd <= 1'b1;
      @(posedge core_clk);
      retire_cmd <= 1'b0;
   endtask

   // return, then one instruction so the controller may serve again
   task leave();
      @(posedge core_clk);
      ret_cmd <= 1'b1;
      @(posedge core_clk);
      ret_cmd <= 1'b0;
      retire();
   endtask

   function automatic logic [PC_W-1:0] va(input int v);
      return PC_W'(VEC_BASE + VEC_STRIDE * PC_W'(v));
   endfunction

   // bounded wait; a missing ack shows as a pc_load mismatch
   task automatic wait_ack(input logic [PC_W-1:0] a, input logic [2:0] l);
      int n;
      n = 0;
      do begin @(posedge core_clk); n++; end
      while (pc_load !== 1'b1 && n < 40);
      `CHK(pc_load, 1'b1)
      `CHK(pc_addr, a)
      `CHK(ack_level, l)
   endtask

   task automatic no_ack(input int c);
      repeat (c) begin @(posedge core_clk); `CHK(pc_load, 1'b0) end
   endtask

   task t_regs();
      chk_rd(OFF_CTRL, 32'h0, RESP_OKAY);
      chk_rd(OFF_PRIO, 32'(PRIO_RST), RESP_OKAY);
      chk_rd(OFF_L1VEC, 32'(L1VEC_RST), RESP_OKAY);
      chk_rd(OFF_STATE, 32'h0, RESP_OKAY);
      chk_rd(8'h1C, 32'h0, RESP_SLVERR);
      axw(8'h02, 32'h1);
      `CHK(rsp, RESP_SLVERR)
      setreq(16'h0020);
      no_ack(6);
      retire();
      wait_ack(va(5), LVL_NORMAL);
      `CHK(ack_vec, 4'h5)
      `CHK(level_state, 3'(LVL_NORMAL))
      setreq(16'h0000);
      chk_rd(OFF_EVT, 32'h1, RESP_OKAY);
      axw(OFF_MASK, 32'h1);
      @(posedge core_clk);
      `CHK(irq_out, 1'b1)
      axw(OFF_EVT, 32'h1);
      @(posedge core_clk);
      `CHK(irq_out, 1'b0)
      leave();
      `CHK(level_state, LVL_NONE)
   endtask

   task t_nmi();
      set_ie(1'b0);
      setreq(16'h0008);
      no_ack(8);
      setreq(16'h0009);
      wait_ack(va(0), LVL_NMI);
      set_ie(1'b1);
      retire();
      no_ack(8);
      setreq(16'h0000);
      leave();
      `CHK(level_state, LVL_NONE)
   endtask

   task t_order();
      setreq(16'h0088);
      wait_ack(va(3), LVL_NORMAL);
      setreq(16'h0000);
      leave();
      axw(OFF_PRIO, 32'h5);
      setreq(16'h0088);
      wait_ack(va(7), LVL_NORMAL);
      setreq(16'h0000);
      leave();
      axw(OFF_PRIO, 32'h0);
      // a source with its enable off never reaches the controller
      src_en <= 16'hFFF7;
      setreq(16'h0088);
      wait_ack(va(7), LVL_NORMAL);
      chk_rd(OFF_PEND, 32'h0000_0080, RESP_OKAY);
      setreq(16'h0000);
      src_en <= '1;
      chk_rd(OFF_PEND, 32'h0000_0000, RESP_OKAY);
      leave();
   endtask

   task t_preempt();
      axw(OFF_L1VEC, 32'h89);
      setreq(16'h0010);
      wait_ack(va(4), LVL_NORMAL);
      setreq(16'h0210);
      no_ack(6);
      retire();
      wait_ack(va(9), LVL_HIGH);
      `CHK(level_state, 3'b011)
      setreq(16'h0000);
      leave();
      `CHK(level_state, 3'(LVL_NORMAL))
      leave();
      `CHK(level_state, LVL_NONE)
   endtask

   task t_rr();
      axw(OFF_CTRL, 32'h1);
      setreq(16'h0044);
      wait_ack(va(2), LVL_NORMAL);
      setreq(16'h0040);
      leave();
      wait_ack(va(6), LVL_NORMAL);
      chk_rd(OFF_PRIO, 32'h6, RESP_OKAY);
      setreq(16'h00C0);
      leave();
      wait_ack(va(7), LVL_NORMAL);
      setreq(16'h0000);
      leave();
      axw(OFF_CTRL, 32'h0);
      axw(OFF_PRIO, 32'h0);
   endtask

   task t_cvt();
      axw(OFF_CTRL, 32'h2);
      setreq(16'h0080);
      wait_ack(CVT_L0_ADDR, LVL_NORMAL);
      setreq(16'h0200);
      retire();
      wait_ack(CVT_L1_ADDR, LVL_HIGH);
      setreq(16'h0000);
      leave();
      leave();
      setreq(16'h0001);
      wait_ack(CVT_NMI_ADDR, LVL_NMI);
      setreq(16'h0000);
      leave();
      axw(OFF_CTRL, 32'h0);
   endtask

   // a halted core must see no redirect however long the request stands
   task t_halt();
      @(posedge core_clk);
      debug_halt <= 1'b1;
      setreq(16'h0020);
      no_ack(10);
      @(posedge core_clk);
      debug_halt <= 1'b0;
      wait_ack(va(5), LVL_NORMAL);
      setreq(16'h0000);
      leave();
   endtask

   initial begin
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      t_regs();
      t_nmi();
      t_order();
      t_preempt();
      t_rr();
      t_cvt();
      t_halt();
      print_verdict();
   end

   // whole run needs well under two thousand cycles
   initial begin
      repeat (6000) @(posedge core_clk);
      errors++;
      print_verdict();
   end
endmodule
